// file: dpd_top.sv
`timescale 1ns/100ps
`include "dpd_params.svh"
module dpd_top #(
   parameter logic [12:0] FAST_HOLDOFF_CLKS = `DPD_FAST_HOLDOFF
) (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic POWER_FAIL_DETECT,
   input wire logic STANDBY_CLOCK,
   input wire logic REFRESH_REQUEST_INPUT,
   input wire logic PROCESSOR_CLASS_SELECT,
   input wire logic DRAM_SPEED_SELECT,
   input wire logic CLOCK_FREQUENCY_SELECT,
   input wire logic ACCESS_REQ,
   input wire logic ACCESS_WRITE,
   input wire logic ACCESS_BANK,
   input wire logic [8:0] ACCESS_ROW,
   input wire logic [8:0] ACCESS_COL,
   output dpd_pkg::dpd_dram_t DRAM,
   output logic ACCESS_TAKEN,
   output logic ACCESS_BLOCKED,
   output logic STANDBY_MODE,
   output logic INTERNAL_RESET
);
   import dpd_pkg::*;

   // ************************************************
   // synchronised pins
   // ************************************************
   logic [5:0] sync_s;
   logic pfd_s, sbclk_s, refresh_request_input_s, class_s, speed_s, freq_s;
   logic sbclk_prev_q, refresh_request_input_prev_q;
   logic sb_rise, refresh_request_input_rise;

   dpd_sync #(.W(6)) u_sync (
      .clk(MCLK),
      .d({POWER_FAIL_DETECT, STANDBY_CLOCK, REFRESH_REQUEST_INPUT,
          PROCESSOR_CLASS_SELECT, DRAM_SPEED_SELECT, CLOCK_FREQUENCY_SELECT}),
      .q(sync_s)
   );

   assign {pfd_s, sbclk_s, refresh_request_input_s, class_s, speed_s, freq_s} = sync_s;

   always_ff @(posedge MCLK) begin
      sbclk_prev_q <= sbclk_s;
      refresh_request_input_prev_q <= refresh_request_input_s;
   end

   assign sb_rise = sbclk_s && !sbclk_prev_q;
   assign refresh_request_input_rise = refresh_request_input_s && !refresh_request_input_prev_q;

   // ************************************************
   // configuration decode
   // ************************************************
   function automatic dpd_cfg_t cfg_decode_f(input logic cls, input logic spd, input logic frq);
      dpd_cfg_t c;
      c = CFG_C0;
      if (!cls) begin
         c = CFG_C2;
      end else if (!spd && frq) begin
         c = CFG_C1;
      end
      return c;
   endfunction

   function automatic dpd_edges_t edges_f(input dpd_cfg_t c, input logic wr);
      dpd_edges_t e;
      e = `DPD_C0_RD_EDGES;
      unique case (c)
         CFG_C0: e = wr ? dpd_edges_t'(`DPD_C0_WR_EDGES) : dpd_edges_t'(`DPD_C0_RD_EDGES);
         CFG_C1: e = wr ? dpd_edges_t'(`DPD_C1_WR_EDGES) : dpd_edges_t'(`DPD_C1_RD_EDGES);
         CFG_C2: e = wr ? dpd_edges_t'(`DPD_C2_WR_EDGES) : dpd_edges_t'(`DPD_C2_RD_EDGES);
      endcase
      return e;
   endfunction

   // ************************************************
   // state
   // ************************************************
   dpd_state_t state_q;
   dpd_cfg_t cfg_q;
   logic failsafe_q;
   logic [8:0] init_cnt_q;
   logic [8:0] burst_left_q;
   logic [1:0] bursts_q;
   logic core_sel_q;
   logic int_rst_q;
   logic [12:0] holdoff_q;
   logic [7:0] ref_cnt_q;
   logic ref_due_q;
   logic [8:0] row_q;
   logic [2:0] sb_cnt_q;
   logic sb_ras_q;
   logic sb_tick;

   logic cyc_act_q, cyc_wr_q, cyc_ref_q, cyc_bank_q;
   logic [2:0] cyc_cnt_q;
   logic [8:0] cyc_row_q, cyc_col_q;
   dpd_edges_t edg;

   logic idle, start_ref, start_acc;
   dpd_dram_t pins_q, pins_d;
   logic taken_q, blocked_q;

   // core tick follows the standby clock only once the select has moved
   // on a standby edge, so no period is ever cut short
   assign sb_tick = sb_rise && core_sel_q;
   assign idle = !cyc_act_q && !int_rst_q;
   assign edg = edges_f(cfg_q, cyc_wr_q);

   // ************************************************
   // straps, caught during the init period
   // ************************************************
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         cfg_q <= CFG_C2;
         failsafe_q <= 1'b0;
      end else if (state_q == ST_INIT) begin
         cfg_q <= cfg_decode_f(class_s, speed_s, freq_s);
         failsafe_q <= refresh_request_input_s;
      end
   end

   // ************************************************
   // cycle start arbitration
   // ************************************************
   always_comb begin
      start_ref = 1'b0;
      start_acc = 1'b0;
      if (idle && (state_q == ST_RUN) && !pfd_s) begin
         if (burst_left_q != 9'h000 || ref_due_q) begin
            start_ref = 1'b1;
         end else if (ACCESS_REQ && holdoff_q == 13'h0000) begin
            start_acc = 1'b1;
         end
      end else if (idle && (state_q == ST_ENTRY || state_q == ST_RECOVER)) begin
         start_ref = burst_left_q != 9'h000;
      end
   end

   // ************************************************
   // main sequencer
   // ************************************************
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         state_q <= ST_INIT;
         init_cnt_q <= 9'h000;
         burst_left_q <= 9'h000;
         bursts_q <= 2'h0;
         core_sel_q <= 1'b0;
         int_rst_q <= 1'b0;
      end else begin
         int_rst_q <= 1'b0;
         if (start_ref && burst_left_q != 9'h000) begin
            burst_left_q <= burst_left_q - 9'h001;
         end
         unique case (state_q)
            ST_INIT: begin
               if (init_cnt_q == `DPD_INIT_CLKS - 9'h001) begin
                  state_q <= ST_RUN;
               end else begin
                  init_cnt_q <= init_cnt_q + 9'h001;
               end
            end
            ST_RUN: begin
               if (idle && pfd_s) begin
                  if (failsafe_q && refresh_request_input_s) begin
                     state_q <= ST_ENTRY;
                     bursts_q <= `DPD_PD_BURSTS - 2'h1;
                     burst_left_q <= `DPD_PD_BURST_LEN;
                  end else begin
                     state_q <= ST_TO_SB;
                  end
               end else if (refresh_request_input_rise && !failsafe_q && burst_left_q == 9'h000) begin
                  burst_left_q <= `DPD_ORD_BURST_LEN;
               end
            end
            ST_ENTRY, ST_RECOVER: begin
               if (idle && burst_left_q == 9'h000) begin
                  if (bursts_q != 2'h0) begin
                     bursts_q <= bursts_q - 2'h1;
                     burst_left_q <= `DPD_PD_BURST_LEN;
                  end else begin
                     state_q <= (state_q == ST_ENTRY) ? ST_TO_SB : ST_RUN;
                  end
               end
            end
            ST_TO_SB: begin
               if (sb_rise) begin
                  core_sel_q <= 1'b1;
                  state_q <= ST_SB;
               end
            end
            ST_SB: begin
               // leave only between refreshes and off a standby edge
               if (!pfd_s && !sb_ras_q && !sb_tick) begin
                  core_sel_q <= 1'b0;
                  state_q <= ST_TO_SYS;
               end
            end
            ST_TO_SYS: begin
               int_rst_q <= 1'b1;
               state_q <= ST_RECOVER;
               bursts_q <= `DPD_PD_BURSTS - 2'h1;
               burst_left_q <= `DPD_PD_BURST_LEN;
            end
         endcase
      end
   end

   // ************************************************
   // system-clock-only timers
   // ************************************************
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         holdoff_q <= 13'h0000;
      end else if (int_rst_q) begin
         holdoff_q <= (cfg_q == CFG_C2) ? `DPD_SLOW_HOLDOFF : FAST_HOLDOFF_CLKS;
      end else if (holdoff_q != 13'h0000 && !core_sel_q) begin
         holdoff_q <= holdoff_q - 13'h0001;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N || int_rst_q || state_q != ST_RUN) begin
         ref_cnt_q <= 8'h00;
         ref_due_q <= 1'b0;
      end else begin
         ref_cnt_q <= (ref_cnt_q == `DPD_REFRESH_INTERVAL - 8'h01) ? 8'h00 : ref_cnt_q + 8'h01;
         // a new request in the same cycle as the service wins
         if (ref_cnt_q == `DPD_REFRESH_INTERVAL - 8'h01) begin
            ref_due_q <= 1'b1;
         end else if (start_ref) begin
            ref_due_q <= 1'b0;
         end
      end
   end

   // ************************************************
   // refresh row counter, cleared only by the pin reset
   // ************************************************
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         row_q <= 9'h000;
      end else if (start_ref || (sb_tick && sb_ras_q)) begin
         row_q <= row_q + 9'h001;
      end
   end

   // ************************************************
   // standby refresh timer
   // ************************************************
   always_ff @(posedge MCLK) begin
      if (!RESET_N || state_q != ST_SB) begin
         sb_cnt_q <= 3'h0;
         sb_ras_q <= 1'b0;
      end else if (sb_tick) begin
         sb_cnt_q <= (sb_cnt_q == `DPD_SB_PERIOD - 3'h1) ? 3'h0 : sb_cnt_q + 3'h1;
         sb_ras_q <= (sb_cnt_q == 3'h0);
      end
   end

   // ************************************************
   // memory cycle engine
   // ************************************************
   always_ff @(posedge MCLK) begin
      if (!RESET_N || int_rst_q) begin
         cyc_act_q <= 1'b0;
         cyc_cnt_q <= 3'h0;
         cyc_wr_q <= 1'b0;
         cyc_ref_q <= 1'b0;
         cyc_bank_q <= 1'b0;
         cyc_row_q <= 9'h000;
         cyc_col_q <= 9'h000;
      end else if (start_ref || start_acc) begin
         cyc_act_q <= 1'b1;
         cyc_cnt_q <= 3'h0;
         cyc_wr_q <= start_acc && ACCESS_WRITE;
         cyc_ref_q <= start_ref;
         cyc_bank_q <= start_acc && ACCESS_BANK;
         cyc_row_q <= start_ref ? row_q : ACCESS_ROW;
         cyc_col_q <= ACCESS_COL;
      end else if (cyc_act_q) begin
         if (cyc_cnt_q == edg.last) begin
            cyc_act_q <= 1'b0;
         end
         cyc_cnt_q <= cyc_cnt_q + 3'h1;
      end
   end

   // ************************************************
   // pin drive
   // ************************************************
   always_comb begin
      logic ras_on, cas_on;
      ras_on = cyc_act_q && cyc_cnt_q < edg.ras_hi;
      cas_on = cyc_act_q && !cyc_ref_q && cyc_cnt_q >= edg.cas_lo && cyc_cnt_q < edg.cas_hi;
      pins_d.row_strobes_n = 2'h3;
      pins_d.column_strobes_n = 2'h3;
      pins_d.write_strobe = 1'b0;
      pins_d.advance_acknowledge_n = 1'b1;
      pins_d.dram_address_out = {1'b0, row_q};
      if (core_sel_q || state_q == ST_TO_SB || state_q == ST_TO_SYS) begin
         pins_d.row_strobes_n = sb_ras_q ? 2'h0 : 2'h3;
      end else begin
         if (ras_on) begin
            pins_d.row_strobes_n = cyc_ref_q ? 2'h0 : (cyc_bank_q ? 2'h1 : 2'h2);
         end
         if (cas_on) begin
            pins_d.column_strobes_n = cyc_bank_q ? 2'h1 : 2'h2;
         end
         pins_d.write_strobe = cyc_act_q && cyc_wr_q && cyc_cnt_q >= edg.we_lo && cyc_cnt_q < edg.we_hi;
         pins_d.advance_acknowledge_n = !(cyc_act_q && !cyc_ref_q &&
                                          cyc_cnt_q >= edg.ack_lo && cyc_cnt_q < edg.ack_hi);
         if (cyc_act_q) begin
            pins_d.dram_address_out = (!cyc_ref_q && cyc_cnt_q >= edg.cas_lo) ? {1'b0, cyc_col_q}
                                                                               : {1'b0, cyc_row_q};
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         pins_q <= '{row_strobes_n: 2'h3, column_strobes_n: 2'h3, write_strobe: 1'b0,
                     advance_acknowledge_n: 1'b1, dram_address_out: 10'h000};
      end else begin
         pins_q <= pins_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         taken_q <= 1'b0;
         blocked_q <= 1'b1;
      end else begin
         taken_q <= start_acc;
         blocked_q <= state_q != ST_RUN || pfd_s || holdoff_q != 13'h0000;
      end
   end

   assign DRAM = pins_q;
   assign ACCESS_TAKEN = taken_q;
   assign ACCESS_BLOCKED = blocked_q;
   assign STANDBY_MODE = core_sel_q;
   assign INTERNAL_RESET = int_rst_q;
endmodule

// file: dpd_params.svh
// Operation
// - On failure keep state, optional bursts, switch
// - Recovery internal reset keeps config and row
// - Three whole-memory bursts after recovery reset
// - No access 4700 or 3100 clocks after recovery
// - Standby holds acknowledge, column strobes, write inactive
// - Standby drives address and row strobes
// - Standby ignores all but fail, clock, reset
// - Standby burst 256 refreshes, ordinary burst 128
// - Synchronise fail input, sample after 300-clock init
// - No bursts: finish cycle, sync, then switch
// - Requests ignored while power fail asserted
// - Standby refresh every 5 standby clock periods
// - Standby row strobe low one standby period
// - Core logic follows both clocks, others one
// - Cycle counts start at the row strobe clock
// - Three timing configurations from strap bits
// - Entry bursts need refresh request high
`ifndef DPD_PARAMS_SVH
`define DPD_PARAMS_SVH

`define DPD_INIT_CLKS 9'h12C
`define DPD_FAST_HOLDOFF 13'h125C
`define DPD_SLOW_HOLDOFF 13'hC1C
`define DPD_PD_BURSTS 2'h3
`define DPD_PD_BURST_LEN 9'h100
`define DPD_ORD_BURST_LEN 9'h080
`define DPD_REFRESH_INTERVAL 8'h96
`define DPD_SB_PERIOD 3'h5

// edge words: ras_hi, cas_lo, cas_hi, ack_lo, ack_hi, we_lo, we_hi, last
`define DPD_C0_RD_EDGES {3'h3, 3'h1, 3'h3, 3'h1, 3'h4, 3'h0, 3'h0, 3'h5}
`define DPD_C0_WR_EDGES {3'h4, 3'h2, 3'h4, 3'h1, 3'h4, 3'h1, 3'h4, 3'h5}
`define DPD_C1_RD_EDGES {3'h4, 3'h1, 3'h5, 3'h2, 3'h5, 3'h0, 3'h0, 3'h6}
`define DPD_C1_WR_EDGES {3'h5, 3'h2, 3'h5, 3'h2, 3'h5, 3'h1, 3'h5, 3'h6}
`define DPD_C2_RD_EDGES {3'h2, 3'h0, 3'h2, 3'h0, 3'h2, 3'h0, 3'h0, 3'h3}
`define DPD_C2_WR_EDGES {3'h2, 3'h1, 3'h3, 3'h0, 3'h2, 3'h0, 3'h2, 3'h3}

`endif

// file: dpd_pkg.sv
package dpd_pkg;

   typedef enum logic [1:0] {CFG_C0, CFG_C1, CFG_C2} dpd_cfg_t;

   typedef enum logic [2:0] {
      ST_INIT, ST_RUN, ST_ENTRY, ST_TO_SB, ST_SB, ST_TO_SYS, ST_RECOVER
   } dpd_state_t;

   typedef struct packed {
      logic [2:0] ras_hi;
      logic [2:0] cas_lo;
      logic [2:0] cas_hi;
      logic [2:0] ack_lo;
      logic [2:0] ack_hi;
      logic [2:0] we_lo;
      logic [2:0] we_hi;
      logic [2:0] last;
   } dpd_edges_t;

   typedef struct packed {
      logic [1:0] row_strobes_n;
      logic [1:0] column_strobes_n;
      logic write_strobe;
      logic advance_acknowledge_n;
      logic [9:0] dram_address_out;
   } dpd_dram_t;

endpackage

// file: dpd_sync.sv
`timescale 1ns/100ps
module dpd_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // first stage feeds only the second
         always_ff @(posedge clk) begin
            meta_q[i] <= d[i];
            q[i] <= meta_q[i];
         end
      end
   endgenerate
endmodule

// file: dpd_dram_model.sv
`timescale 1ns/100ps
module dpd_dram_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fail_cmd,
   input wire dpd_pkg::dpd_dram_t dram,
   output logic power_fail_detect,
   output logic standby_clock,
   output int refresh_count,
   output int seq_errors
);
   import dpd_pkg::*;
   logic both_q;
   logic have_q;
   logic [8:0] row_q;
   // ****************
   // supply and array
   // ****************
   // own oscillator, phase unrelated to the system clock, never stopped
   initial begin
      standby_clock = 1'b0;
      #13;
      forever #470 standby_clock = ~standby_clock;
   end
   // asynchronous fail line; the supply is back before release
   initial power_fail_detect = 1'b0;
   always @(fail_cmd) power_fail_detect <= #37 fail_cmd;
   initial refresh_count = 0;
   initial seq_errors = 0;
   // both row strobes low means refresh; rows must follow on
   always @(posedge mclk) begin
      both_q <= dram.row_strobes_n == 2'h0;
      if (!rst_n) begin
         have_q <= 1'b0;
      end else if (dram.row_strobes_n == 2'h0 && !both_q) begin
         if (have_q && dram.dram_address_out[8:0] !== row_q + 9'h001) begin
            seq_errors <= seq_errors + 1;
         end
         row_q <= dram.dram_address_out[8:0];
         have_q <= 1'b1;
         refresh_count <= refresh_count + 1;
      end
   end
endmodule

// file: dpd_chk_properties.sv
`timescale 1ns/100ps
module dpd_chk #(
   parameter logic [12:0] FAST_HOLDOFF_CLKS = 13'h0028
) (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic POWER_FAIL_DETECT,
   input wire logic STANDBY_CLOCK,
   input wire dpd_pkg::dpd_dram_t DRAM,
   input wire logic ACCESS_TAKEN,
   input wire logic ACCESS_BLOCKED,
   input wire logic STANDBY_MODE,
   input wire logic INTERNAL_RESET
);
   import dpd_pkg::*;
   logic sbc_q;
   logic ras_q;
   logic seen_q;
   logic [3:0] ticks_q;
   logic [3:0] low_q;
   logic [12:0] hold_q;
   logic [8:0] init_q;
   wire ras = DRAM.row_strobes_n == 2'h0;
   wire rise = STANDBY_CLOCK & ~sbc_q;
   // ****************
   // helper counters
   // ****************
   always_ff @(posedge MCLK) begin
      sbc_q <= STANDBY_CLOCK;
      ras_q <= ras;
   end
   // raw ticks, same sync offset at both ends of a pulse
   always_ff @(posedge MCLK) begin
      if (!RESET_N || !STANDBY_MODE) begin
         seen_q <= 1'b0;
         ticks_q <= 4'h0;
         low_q <= 4'h0;
      end else if (ras && !ras_q) begin
         seen_q <= 1'b1;
         ticks_q <= {3'h0, rise};
         low_q <= {3'h0, rise};
      end else begin
         ticks_q <= ticks_q + {3'h0, rise && ticks_q != 4'hF};
         low_q <= low_q + {3'h0, rise && ras && low_q != 4'hF};
      end
   end
   always_ff @(posedge MCLK) begin
      if (!RESET_N) hold_q <= 13'h1FFF;
      else if (INTERNAL_RESET) hold_q <= 13'h0000;
      else if (hold_q != 13'h1FFF) hold_q <= hold_q + 13'h0001;
   end
   always_ff @(posedge MCLK) begin
      if (!RESET_N) init_q <= 9'h000;
      else if (init_q != 9'h1FF) init_q <= init_q + 9'h001;
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   property p_quiet; STANDBY_MODE |-> DRAM.column_strobes_n == 2'h3 && !DRAM.write_strobe && DRAM.advance_acknowledge_n; endproperty
   a_quiet: assert property (p_quiet) else $error("strobe active in standby");
   property p_rows; STANDBY_MODE && DRAM.row_strobes_n != 2'h3 |-> ras; endproperty
   a_rows: assert property (p_rows) else $error("standby refresh not on both rows");
   property p_period; ras && !ras_q && seen_q |-> ticks_q == 4'h5; endproperty
   a_period: assert property (p_period) else $error("standby refresh spacing");
   property p_pulse; STANDBY_MODE && ras_q && !ras |-> low_q == 4'h1; endproperty
   a_pulse: assert property (p_pulse) else $error("standby row pulse length");
   property p_deaf; STANDBY_MODE |-> !ACCESS_TAKEN; endproperty
   a_deaf: assert property (p_deaf) else $error("access in standby");
   property p_refuse; POWER_FAIL_DETECT [*4] |=> !ACCESS_TAKEN; endproperty
   a_refuse: assert property (p_refuse) else $error("access during fail");
   property p_block; POWER_FAIL_DETECT [*5] |-> ACCESS_BLOCKED; endproperty
   a_block: assert property (p_block) else $error("not blocked during fail");
   property p_ireset; $fell(STANDBY_MODE) |=> INTERNAL_RESET ##1 !INTERNAL_RESET; endproperty
   a_ireset: assert property (p_ireset) else $error("no internal reset on exit");
   property p_hold; hold_q < FAST_HOLDOFF_CLKS |-> !ACCESS_TAKEN; endproperty
   a_hold: assert property (p_hold) else $error("access inside holdoff");
   property p_init; init_q < 9'h12C |-> !STANDBY_MODE && !ACCESS_TAKEN; endproperty
   a_init: assert property (p_init) else $error("activity during init");
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
`include "dpd_params.svh"
module tb_top;
   import dpd_pkg::*;
   logic mclk, rst_n, refresh_request_input, cls, spd, frq, req, wr_i, bank, fail_cmd;
   logic pfd, sbclk, taken, blocked, sb_mode, int_rst;
   logic [8:0] row, col;
   dpd_dram_t dram;
   int failures, compares, cycles, rcnt, serr;
   integer seed = 32'h76BE28F1;
   dpd_top #(.FAST_HOLDOFF_CLKS(13'h0028)) u_dut (.MCLK(mclk), .RESET_N(rst_n), .POWER_FAIL_DETECT(pfd),
      .STANDBY_CLOCK(sbclk), .REFRESH_REQUEST_INPUT(refresh_request_input), .PROCESSOR_CLASS_SELECT(cls), .DRAM_SPEED_SELECT(spd),
      .CLOCK_FREQUENCY_SELECT(frq), .ACCESS_REQ(req), .ACCESS_WRITE(wr_i), .ACCESS_BANK(bank), .ACCESS_ROW(row),
      .ACCESS_COL(col), .DRAM(dram), .ACCESS_TAKEN(taken), .ACCESS_BLOCKED(blocked), .STANDBY_MODE(sb_mode),
      .INTERNAL_RESET(int_rst));
   dpd_dram_model u_model (.mclk(mclk), .rst_n(rst_n), .fail_cmd(fail_cmd), .dram(dram),
      .power_fail_detect(pfd), .standby_clock(sbclk), .refresh_count(rcnt), .seq_errors(serr));
   // ****************
   // bench tasks
   // ****************
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures = failures + 1;
         wrap_up();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (failures == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask
   function automatic logic [11:0] exp_len(input int cfg, input logic wr);
      dpd_edges_t e;
      if (cfg == 0) e = wr ? `DPD_C0_WR_EDGES : `DPD_C0_RD_EDGES;
      else if (cfg == 1) e = wr ? `DPD_C1_WR_EDGES : `DPD_C1_RD_EDGES;
      else e = wr ? `DPD_C2_WR_EDGES : `DPD_C2_RD_EDGES;
      return {e.ras_hi, e.cas_hi - e.cas_lo, e.ack_hi - e.ack_lo, e.we_hi - e.we_lo};
   endfunction
   task automatic reset_dut(input int cfg, input logic rf);
      @(posedge mclk);
      rst_n <= 1'b0;
      refresh_request_input <= rf;
      {cls, spd, frq} <= cfg == 0 ? 3'h6 : cfg == 1 ? 3'h5 : {1'b0, 2'($random(seed))};
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (320) @(posedge mclk);
   endtask
   // request stays up until taken; then every strobe of the cycle is timed
   task automatic take_meas(input int cfg, input int lim, output int n);
      logic [2:0] rl, cl, al, wl;
      #1;
      for (n = 0; taken !== 1'b1 && n < lim; n++) tick();
      req <= 1'b0;
      {rl, cl, al, wl} = 12'h000;
      repeat (8) begin
         tick();
         rl += 3'(dram.row_strobes_n === {~bank, bank});
         // row may still stand at the row strobe; column must stand under the column strobe
         if (dram.column_strobes_n[bank] === 1'b0) begin
            if (cl == 3'h0) check(32'(dram.dram_address_out), 32'(col));
            cl++;
         end
         al += 3'(dram.advance_acknowledge_n === 1'b0);
         wl += 3'(dram.write_strobe === 1'b1);
      end
      check(32'(n < lim), 32'h1);
      check(32'({rl, cl, al, wl}), 32'(exp_len(cfg, wr_i)));
   endtask
   task automatic do_access(input int cfg, input logic wr);
      int n;
      @(posedge mclk);
      req <= 1'b1;
      {bank, row, col} <= 19'($random(seed));
      wr_i <= wr;
      take_meas(cfg, 400, n);
      check(32'(blocked), 32'h0);
   endtask
   task automatic power_cycle(input int cfg, input logic burst);
      int n, r0;
      @(posedge mclk);
      fail_cmd <= 1'b1;
      #1;
      r0 = rcnt;
      for (n = 0; sb_mode !== 1'b1 && n < 6000; n++) begin
         tick();
         req <= 1'(n > 8);
      end
      check(32'(rcnt - r0 >= 768), 32'(burst));
      check(32'(n < (burst ? 6000 : 60)), 32'h1);
      r0 = rcnt;
      // noise on every input the standby logic must not hear
      repeat (400) begin
         @(posedge mclk);
         {cls, spd, frq, refresh_request_input, req, wr_i, bank, row, col} <= 25'($random(seed));
      end
      #1;
      check(32'(rcnt - r0 >= 6), 32'h1);
      check(32'(blocked), 32'h1);
      @(posedge mclk);
      // straps now select configuration 0; the kept configuration must still time the access
      {cls, spd, frq, refresh_request_input, req, wr_i} <= 6'h32;
      fail_cmd <= 1'b0;
      for (n = 0; int_rst !== 1'b1 && n < 200; n++) tick();
      r0 = rcnt;
      take_meas(cfg, 8000, n);
      check(32'(n >= (cfg == 2 ? 3100 : 40)), 32'h1);
      check(32'(rcnt - r0 >= 768), 32'h1);
   endtask
   initial begin
      int r0;
      {rst_n, refresh_request_input, cls, spd, frq, req, wr_i, bank, fail_cmd} = 9'h000;
      {row, col} = 18'h00000;
      failures = 0;
      compares = 0;
      cycles = 0;
      for (int c = 0; c < 3; c++) begin
         reset_dut(c, 1'b0);
         do_access(c, 1'b0);
         do_access(c, 1'b1);
         @(posedge mclk);
         refresh_request_input <= 1'b1;
         #1;
         r0 = rcnt;
         // slowest configuration needs about 1030 clocks for a full burst
         repeat (1200) tick();
         check(32'(rcnt - r0 >= 128 && rcnt - r0 <= 136), 32'h1);
         refresh_request_input <= 1'b0;
      end
      power_cycle(2, 1'b0);
      reset_dut(0, 1'b1);
      power_cycle(0, 1'b1);
      // failsafe strapped but request low at detection: straight into standby
      power_cycle(0, 1'b0);
      check(32'(serr), 32'h0);
      wrap_up();
   end
endmodule
bind dpd_top dpd_chk #(.FAST_HOLDOFF_CLKS(FAST_HOLDOFF_CLKS)) u_chk (.MCLK(MCLK), .RESET_N(RESET_N),
   .POWER_FAIL_DETECT(POWER_FAIL_DETECT), .STANDBY_CLOCK(STANDBY_CLOCK), .DRAM(DRAM), .ACCESS_TAKEN(ACCESS_TAKEN),
   .ACCESS_BLOCKED(ACCESS_BLOCKED), .STANDBY_MODE(STANDBY_MODE), .INTERNAL_RESET(INTERNAL_RESET));
